/* File: logic/ext_bus_ctl.sv */
// external bus mode, paging port and stretch control with apb registers
// assumes one clock; cpu side holds cpu_req until cpu_done
// Notes on behaviour
// - direction bit makes paging pin input or output
// - direction register echoed externally under page emulation
// - byte access strobe and bit zero encoding
// - word access encoding, odd word swaps halves
// - strobe and bit zero high: misaligned ram word
// - external cycles stretch zero to three periods
// - processor holds, write data stays driven
// - read data captured at e falling edge
// - selects and read/write valid through stretch
// - address phase never stretched
// - mode pins latched at reset release
// - three mode bits decode to eight modes
// - debug active at reset only in special single
// - normal modes protect controls, special modes not
// - interrupt pins start as pulled-up inputs
// - reset sets stretch enable in user modes
// - mode pins high impedance during reset
// - stretch enable chooses free or stretched e
// - value read returns pin or latch by direction
`timescale 1ns/10ps
module ext_bus_ctl
    import ext_bus_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_req,
    input wire logic cpu_wr,
    input wire logic cpu_word,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic cpu_hold,
    output logic cpu_done,
    output logic [15:0] cpu_rdata,
    input wire logic [1:0] stretch_sel,
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out,
    output logic ad_oe,
    output logic low_byte_strobe,
    output logic address_bit_zero,
    output logic rd_wr,
    output logic chip_select,
    output logic bus_e_clock,
    input wire logic mode_select_c,
    input wire logic mode_select_b,
    input wire logic mode_select_a,
    input wire logic [1:0] pipe_status_in,
    input wire logic pipe_out_req,
    output logic pipe_status_high,
    output logic pipe_status_low,
    output logic pipe_oe,
    input wire logic [7:0] paging_pin_in,
    output logic [7:0] paging_pin_out,
    output logic [7:0] paging_pin_oe,
    input wire logic irq_unmask,
    input wire logic nmi_unmask,
    output logic [1:0] pe_int_route,
    output logic [1:0] pe_pullup_en,
    input wire logic debug_enable_cmd,
    output logic background_debug_active
);
    logic init_done_ff;
    logic [2:0] mode_ff, nxt_mode;
    logic page_emulation_enable_ff, nxt_pee;
    logic e_clock_stretch_enable_ff, nxt_e_clock_stretch_enable;
    logic mode_wrote_ff, nxt_mode_wrote, ctl_wrote_ff, nxt_ctl_wrote;
    logic [7:0] paging_port_direction_ff, nxt_dir;
    logic [7:0] paging_port_value_ff, nxt_val;
    logic bdm_ff, nxt_bdm;
    logic own_apb_ff, nxt_own;
    logic [1:0] pipe_ff;

    logic [7:0] idx;
    logic apb_acc, hit_local, hit_echo, wr_local, special, expanded;
    logic seq_idle, seq_done, grant_echo, grant_cpu, seq_req;
    logic seq_wr, seq_word;
    logic [15:0] seq_addr, seq_wdata, seq_rdata;
    logic [7:0] page_rd;

    // special modes: special single chip, special test, peripheral
    function automatic logic is_special(input logic [2:0] m);
        is_special = (m == MODE_SPECIAL_SINGLE) | (m == MODE_SPECIAL_TEST)
            | (m == MODE_PERIPHERAL);
    endfunction

    function automatic logic is_expanded(input logic [2:0] m);
        is_expanded = (m != MODE_SPECIAL_SINGLE) & (m != MODE_NORMAL_SINGLE);
    endfunction

    assign special = is_special(mode_ff);
    assign expanded = is_expanded(mode_ff);
    assign idx = paddr[9:ADDR_SHIFT];
    assign apb_acc = psel & penable;

    // paging port registers leave the map under page emulation
    assign hit_echo = page_emulation_enable_ff & expanded
        & ((idx == IDX_PAGE_DIR) | (idx == IDX_PAGE_VALUE));
    assign hit_local = ~hit_echo & ((idx == IDX_PAGE_DIR) | (idx == IDX_PAGE_VALUE)
        | (idx == IDX_MODE) | (idx == IDX_BUS_CTL));
    assign wr_local = apb_acc & pwrite & hit_local;

    // echoed access takes the bus when the sequencer is free
    assign grant_echo = apb_acc & hit_echo & seq_idle & ~seq_done & ~own_apb_ff;
    assign grant_cpu = cpu_req & seq_idle & ~seq_done & ~grant_echo & ~own_apb_ff;
    assign seq_req = grant_echo | grant_cpu;
    assign seq_wr = grant_echo ? pwrite : cpu_wr;
    assign seq_word = grant_echo ? 1'b0 : cpu_word;
    assign seq_addr = grant_echo ? {8'h00, idx} : cpu_addr;
    assign seq_wdata = grant_echo ? {pwdata[7:0], pwdata[7:0]} : cpu_wdata;

    // processor held for the whole cycle including stretch
    assign cpu_done = seq_done & ~own_apb_ff;
    assign cpu_hold = cpu_req & ~cpu_done;
    assign cpu_rdata = seq_rdata;

    // pin value when input, latch when output
    assign page_rd = (paging_port_direction_ff & paging_port_value_ff)
        | (~paging_port_direction_ff & paging_pin_in);

    always_comb
    begin
        pready = 1'b1;
        pslverr = 1'b0;
        prdata = 32'h0000_0000;
        if (psel & hit_echo)
        begin
            pready = seq_done & own_apb_ff;
            prdata = {24'h00_0000, idx[0] ? seq_rdata[7:0] : seq_rdata[15:8]};
        end
        else if (psel & ~hit_local)
        begin
            pslverr = penable;
        end
        else if (idx == IDX_PAGE_DIR)
        begin
            prdata = {24'h00_0000, paging_port_direction_ff};
        end
        else if (idx == IDX_PAGE_VALUE)
        begin
            prdata = {24'h00_0000, page_rd};
        end
        else if (idx == IDX_MODE)
        begin
            prdata[MODE_C_BIT -: 3] = mode_ff;
            prdata[PAGE_EMU_BIT] = page_emulation_enable_ff;
        end
        else
        begin
            prdata[E_CLOCK_STRETCH_ENABLE_BIT] = e_clock_stretch_enable_ff;
        end
    end

    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_pee = page_emulation_enable_ff;
        nxt_e_clock_stretch_enable = e_clock_stretch_enable_ff;
        nxt_mode_wrote = mode_wrote_ff;
        nxt_ctl_wrote = ctl_wrote_ff;
        nxt_dir = paging_port_direction_ff;
        nxt_val = paging_port_value_ff;
        nxt_bdm = bdm_ff | debug_enable_cmd;
        nxt_own = own_apb_ff;
        if (!init_done_ff)
        begin
            // first edge after reset release takes the straps
            nxt_mode = {mode_select_c, mode_select_b, mode_select_a};
            // user modes start with stretch on for a slow reset vector
            nxt_e_clock_stretch_enable = ~is_special({mode_select_c, mode_select_b, mode_select_a});
            nxt_bdm = ({mode_select_c, mode_select_b, mode_select_a}
                == MODE_SPECIAL_SINGLE) | debug_enable_cmd;
        end
        else if (wr_local)
        begin
            if (idx == IDX_PAGE_DIR)
            begin
                nxt_dir = pwdata[7:0];
            end
            if (idx == IDX_PAGE_VALUE)
            begin
                nxt_val = pwdata[7:0];
            end
            // normal modes allow one write, special modes any number
            if ((idx == IDX_MODE) & (special | ~mode_wrote_ff))
            begin
                nxt_mode_wrote = 1'b1;
                nxt_pee = pwdata[PAGE_EMU_BIT];
                // mode change limited: peripheral never entered by software
                if (pwdata[MODE_C_BIT -: 3] != MODE_PERIPHERAL)
                begin
                    nxt_mode = pwdata[MODE_C_BIT -: 3];
                end
            end
            if ((idx == IDX_BUS_CTL) & (special | ~ctl_wrote_ff))
            begin
                nxt_ctl_wrote = 1'b1;
                nxt_e_clock_stretch_enable = pwdata[E_CLOCK_STRETCH_ENABLE_BIT];
            end
        end
        if (grant_echo)
        begin
            nxt_own = 1'b1;
        end
        else if (seq_done)
        begin
            nxt_own = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            init_done_ff <= 1'b0;
            mode_ff <= MODE_SPECIAL_SINGLE;
            page_emulation_enable_ff <= 1'b0;
            e_clock_stretch_enable_ff <= 1'b0;
            mode_wrote_ff <= 1'b0;
            ctl_wrote_ff <= 1'b0;
            paging_port_direction_ff <= DIR_RESET;
            paging_port_value_ff <= 8'h00;
            bdm_ff <= 1'b0;
            own_apb_ff <= 1'b0;
            pipe_ff <= 2'h0;
        end
        else
        begin
            init_done_ff <= 1'b1;
            mode_ff <= nxt_mode;
            page_emulation_enable_ff <= nxt_pee;
            e_clock_stretch_enable_ff <= nxt_e_clock_stretch_enable;
            mode_wrote_ff <= nxt_mode_wrote;
            ctl_wrote_ff <= nxt_ctl_wrote;
            paging_port_direction_ff <= nxt_dir;
            paging_port_value_ff <= nxt_val;
            bdm_ff <= nxt_bdm;
            own_apb_ff <= nxt_own;
            pipe_ff <= pipe_status_in;
        end
    end

    // stretch enable has no effect in single chip modes
    ext_cycle_seq u_seq (
        .clk(clk),
        .arst_n(arst_n),
        .req(seq_req),
        .wr(seq_wr),
        .word(seq_word),
        .addr(seq_addr),
        .wdata(seq_wdata),
        .stretch_sel(stretch_sel),
        .e_clock_stretch_enable_en(e_clock_stretch_enable_ff & expanded),
        .ad_in(ad_in),
        .idle(seq_idle),
        .done_ff(seq_done),
        .rdata_ff(seq_rdata),
        .ad_out_ff(ad_out),
        .ad_oe_ff(ad_oe),
        .low_byte_strobe_ff(low_byte_strobe),
        .address_bit_zero_ff(address_bit_zero),
        .rd_wr_ff(rd_wr),
        .cs_ff(chip_select),
        .bus_e_clock_ff(bus_e_clock)
    );

    // pins are plain outputs only while not emulating the page
    assign paging_pin_out = paging_port_value_ff;
    assign paging_pin_oe = (page_emulation_enable_ff & expanded) ? 8'h00
        : paging_port_direction_ff;

    // shared pipe/mode pins stay released until straps are taken
    assign pipe_oe = init_done_ff & pipe_out_req;
    assign pipe_status_high = pipe_ff[1];
    assign pipe_status_low = pipe_ff[0];

    // both interrupt inputs inhibited until the core unmasks them
    assign pe_int_route = {irq_unmask, nmi_unmask};
    assign pe_pullup_en = PE_PULLUP_RESET;
    assign background_debug_active = bdm_ff;
endmodule // ext_bus_ctl

/* File: logic/ext_bus_pkg.sv */
// constants shared by the external bus control block
// assumes a 100 MHz internal bus clock and an apb register port
package ext_bus_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PAGE_VALUE = 8'h32;
    localparam logic [7:0] IDX_PAGE_DIR = 8'h33;
    localparam logic [7:0] IDX_MODE = 8'h0b;
    localparam logic [7:0] IDX_BUS_CTL = 8'h0e;
    localparam int ADDR_SHIFT = 2;
    // mode register fields
    localparam int MODE_C_BIT = 7;
    localparam int MODE_A_BIT = 5;
    localparam int PAGE_EMU_BIT = 0;
    // bus interface control fields
    localparam int E_CLOCK_STRETCH_ENABLE_BIT = 0;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [1:0] PE_PULLUP_RESET = 2'h3;
    typedef enum logic [2:0] {
        MODE_SPECIAL_SINGLE = 3'b000,
        MODE_EMU_NARROW = 3'b001,
        MODE_SPECIAL_TEST = 3'b010,
        MODE_EMU_WIDE = 3'b011,
        MODE_NORMAL_SINGLE = 3'b100,
        MODE_NORMAL_NARROW = 3'b101,
        MODE_PERIPHERAL = 3'b110,
        MODE_NORMAL_WIDE = 3'b111
    } mode_e;
    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_ADDR = 2'b01,
        CYC_DATA = 2'b10
    } cyc_state_e;
endpackage

/* File: logic/ext_cycle_seq.sv */
// one external bus cycle: address phase, data phase, stretch
// assumes req is raised only while idle and done is low; stretch_sel comes from core control
`timescale 1ns/10ps
module ext_cycle_seq
    import ext_bus_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req,
    input wire logic wr,
    input wire logic word,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] stretch_sel,
    input wire logic e_clock_stretch_enable_en,
    input wire logic [15:0] ad_in,
    output logic idle,
    output logic done_ff,
    output logic [15:0] rdata_ff,
    output logic [15:0] ad_out_ff,
    output logic ad_oe_ff,
    output logic low_byte_strobe_ff,
    output logic address_bit_zero_ff,
    output logic rd_wr_ff,
    output logic cs_ff,
    output logic bus_e_clock_ff
);
    cyc_state_e state_ff, nxt_state;
    logic [1:0] cnt_ff, nxt_cnt;
    logic [15:0] addr_ff, nxt_addr, wd_ff, nxt_wd, nxt_rdata, nxt_ad;
    logic wr_ff, nxt_wr, word_ff, nxt_word, nxt_low_byte_strobe, nxt_ab0, nxt_done, nxt_e, swap;

    assign idle = (state_ff == CYC_IDLE);
    assign swap = word_ff & addr_ff[0];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wd = wd_ff;
        nxt_wr = wr_ff;
        nxt_word = word_ff;
        nxt_rdata = rdata_ff;
        nxt_done = 1'b0;
        nxt_low_byte_strobe = low_byte_strobe_ff;
        nxt_ab0 = address_bit_zero_ff;
        unique case (state_ff)
            CYC_IDLE:
            begin
                if (req)
                begin
                    nxt_state = CYC_ADDR;
                    nxt_addr = addr;
                    nxt_wr = wr;
                    nxt_word = word;
                    // odd word: halves exchanged on the bus
                    nxt_wd = (word & addr[0]) ? {wdata[7:0], wdata[15:8]} : wdata;
                    nxt_ab0 = addr[0];
                    nxt_low_byte_strobe = word ? addr[0] : ~addr[0];
                end
            end
            CYC_ADDR:
            begin
                // address phase is always one period, stretch never applies
                nxt_state = CYC_DATA;
                nxt_cnt = stretch_sel;
            end
            CYC_DATA:
            begin
                if (cnt_ff == 2'h0)
                begin
                    // read data taken at the falling edge of e
                    nxt_rdata = swap ? {ad_in[7:0], ad_in[15:8]} : ad_in;
                    nxt_done = 1'b1;
                    nxt_state = CYC_IDLE;
                end
                else
                begin
                    nxt_cnt = cnt_ff - 2'h1;
                end
            end
            default:
            begin
                nxt_state = CYC_IDLE;
            end
        endcase
        // write data keeps driving through the whole stretch
        nxt_ad = (nxt_state == CYC_DATA) ? nxt_wd : nxt_addr;
        // e_clock_stretch_enable=0: free running, else high only in data phase
        nxt_e = e_clock_stretch_enable_en ? (nxt_state == CYC_DATA) : ~bus_e_clock_ff;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= CYC_IDLE;
            cnt_ff <= 2'h0;
            addr_ff <= 16'h0000;
            wd_ff <= 16'h0000;
            wr_ff <= 1'b0;
            word_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            done_ff <= 1'b0;
            ad_out_ff <= 16'h0000;
            ad_oe_ff <= 1'b0;
            low_byte_strobe_ff <= 1'b0;
            address_bit_zero_ff <= 1'b0;
            rd_wr_ff <= 1'b1;
            cs_ff <= 1'b0;
            bus_e_clock_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wd_ff <= nxt_wd;
            wr_ff <= nxt_wr;
            word_ff <= nxt_word;
            rdata_ff <= nxt_rdata;
            done_ff <= nxt_done;
            ad_out_ff <= nxt_ad;
            ad_oe_ff <= (nxt_state == CYC_ADDR) | ((nxt_state == CYC_DATA) & nxt_wr);
            low_byte_strobe_ff <= nxt_low_byte_strobe;
            address_bit_zero_ff <= nxt_ab0;
            // select and direction held for all of e high
            rd_wr_ff <= (nxt_state == CYC_IDLE) | ~nxt_wr;
            cs_ff <= (nxt_state != CYC_IDLE);
            bus_e_clock_ff <= nxt_e;
        end
    end
endmodule // ext_cycle_seq

/* File: sim/ext_bus_sva.sv */
// checker for the external bus control block
// assumes it is bound onto ext_bus_ctl and sees only its ports
`timescale 1ns/10ps
module ext_bus_sva
    import ext_bus_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cpu_wr,
    input wire logic cpu_word,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_done,
    input wire logic cpu_hold,
    input wire logic [15:0] cpu_rdata,
    input wire logic [1:0] stretch_sel,
    input wire logic [15:0] ad_in,
    input wire logic [15:0] ad_out,
    input wire logic ad_oe,
    input wire logic low_byte_strobe,
    input wire logic address_bit_zero,
    input wire logic rd_wr,
    input wire logic chip_select,
    input wire logic [7:0] paging_pin_oe,
    input wire logic pipe_oe,
    input wire logic irq_unmask,
    input wire logic nmi_unmask,
    input wire logic [1:0] pe_int_route,
    input wire logic [1:0] pe_pullup_en,
    input wire logic debug_enable_cmd,
    input wire logic background_debug_active
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    always_comb
    begin
        nxt_cnt = chip_select ? cnt_ff + 3'h1 : 3'h0;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_ff <= 3'h0;
        else
            cnt_ff <= nxt_cnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_start;
        $rose(chip_select) && cpu_hold;
    endsequence
    sequence s_addr;
        $rose(chip_select) && ad_oe;
    endsequence
    a_stretch_len: assert property ($fell(chip_select) && cnt_ff != 3'h0
        |-> cnt_ff == {1'b0, stretch_sel} + 3'h2) else $error("select length wrong");
    a_addr_phase: assert property (s_addr |=> (rd_wr ? !ad_oe : ad_oe))
        else $error("address phase length wrong");
    a_rw_hold: assert property (chip_select && $past(chip_select) |-> $stable(rd_wr))
        else $error("read/write moved in cycle");
    a_wdata_hold: assert property (chip_select && !rd_wr && $past(chip_select, 2)
        |-> $stable(ad_out) && ad_oe) else $error("write data moved");
    a_access_code: assert property (s_start |-> address_bit_zero == cpu_addr[0]
        && low_byte_strobe == (cpu_addr[0] ~^ cpu_word) && rd_wr == !cpu_wr)
        else $error("access encoding wrong");
    a_read_capture: assert property (cpu_done && cpu_word && !cpu_addr[0]
        && $past(rd_wr && chip_select) |-> cpu_rdata == $past(ad_in))
        else $error("read data not captured");
    a_reset_pins: assert property (disable iff (1'b0) !arst_n
        |-> paging_pin_oe == DIR_RESET && !pipe_oe) else $error("pins driven in reset");
    a_int_pins: assert property (pe_pullup_en == PE_PULLUP_RESET
        && pe_int_route == {irq_unmask, nmi_unmask}) else $error("interrupt pins wrong");
    a_debug_cmd: assert property (debug_enable_cmd |=> background_debug_active)
        else $error("debug not activated");
endmodule // ext_bus_sva
bind ext_bus_ctl ext_bus_sva u_sva (.*);

/* File: sim/ext_mem_model.sv */
// word memory on the multiplexed bus
// assumes address on ad_out in the first select cycle
`timescale 1ns/10ps
module ext_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic chip_select,
    input wire logic rd_wr,
    input wire logic [15:0] ad_out,
    output logic [15:0] ad_in
);
    logic [15:0] mem [0:15];
    logic [3:0] adr_ff;
    logic [15:0] last_ff = 16'h0;
    logic sel_ff = 1'b0;
    logic late_ff = 1'b0;
    logic drive;
    // a slow part has data only from the second data cycle on
    assign drive = chip_select && sel_ff && rd_wr && (late_ff || !slow);
    // released bus flips every cycle so stale data never matches
    assign ad_in = drive ? mem[adr_ff] : ~last_ff;
    always @(posedge clk)
    begin
        sel_ff <= chip_select;
        late_ff <= chip_select && sel_ff;
        last_ff <= ad_in;
        if (chip_select && !sel_ff)
            adr_ff <= ad_out[4:1];
        if (chip_select && sel_ff && !rd_wr)
            mem[adr_ff] <= ad_out;
    end
endmodule // ext_mem_model

/* File: sim/tb_top.sv */
// self-checking bench for the external bus control block
// assumes the checker binds itself and the memory model answers the bus
`timescale 1ns/10ps
module tb_top;
    import ext_bus_pkg::*;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, slow;
    logic cpu_req, cpu_wr, cpu_word, cpu_hold, cpu_done, ad_oe, rd_wr, chip_select;
    logic low_byte_strobe, address_bit_zero, bus_e_clock, pipe_oe, pipe_out_req;
    logic mode_select_c, mode_select_b, mode_select_a, pipe_status_high, pipe_status_low;
    logic irq_unmask, nmi_unmask, debug_enable_cmd, background_debug_active;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, ad_in, ad_out;
    logic [1:0] stretch_sel, pipe_status_in, pe_int_route, pe_pullup_en;
    logic [7:0] paging_pin_in, paging_pin_out, paging_pin_oe;
    int fail_count, check_count, cycles, lat;
    ext_bus_ctl dut (.*);
    ext_mem_model mem (.*);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("mismatches %0d checks %0d", fail_count, check_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [31:0] exp, input logic err, output int n);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        // a slave that never answers counts as a mismatch, not a silent pass
        chk(32'(pready), 32'h1);
        if (!wr)
            chk(prdata, exp);
        chk(32'(pslverr), 32'(err));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cpu(input logic wr, input logic word, input logic [15:0] a,
                       input logic [15:0] wd, input logic [15:0] exp);
        int n;
        cpu_req <= 1'b1;
        cpu_wr <= wr;
        cpu_word <= word;
        cpu_addr <= a;
        cpu_wdata <= wd;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cpu_done !== 1'b1 && n < 40);
        chk(32'(cpu_done), 32'h1);
        if (!wr)
            chk(32'(cpu_rdata), 32'(exp));
        cpu_req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset(input logic [2:0] m);
        arst_n <= 1'b0;
        {mode_select_c, mode_select_b, mode_select_a} <= m;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++)
        begin
            if (m == 6)
                continue; // peripheral mode is skipped, though the straps can select it
            do_reset(3'(m));
            apb(1'b0, IDX_MODE, 8'h0, {24'h0, 3'(m), 5'h0}, 1'b0, lat);
            apb(1'b0, IDX_BUS_CTL, 8'h0, 32'(m != 0 && m != 2), 1'b0, lat);
            apb(1'b0, IDX_PAGE_DIR, 8'h0, 32'h0, 1'b0, lat);
            chk(32'(background_debug_active), 32'(m == 0));
        end
    endtask
    task automatic t_protect();
        do_reset(3'b010);
        apb(1'b1, IDX_BUS_CTL, 8'h0, 32'h0, 1'b0, lat);
        apb(1'b1, IDX_BUS_CTL, 8'h1, 32'h0, 1'b0, lat);
        apb(1'b0, IDX_BUS_CTL, 8'h0, 32'h1, 1'b0, lat);
        do_reset(3'b111);
        apb(1'b1, IDX_BUS_CTL, 8'h0, 32'h0, 1'b0, lat);
        apb(1'b1, IDX_BUS_CTL, 8'h1, 32'h0, 1'b0, lat);
        apb(1'b0, IDX_BUS_CTL, 8'h0, 32'h0, 1'b0, lat);
    endtask
    task automatic t_port();
        paging_pin_in <= 8'h0f;
        apb(1'b1, IDX_PAGE_VALUE, 8'h3c, 32'h0, 1'b0, lat);
        apb(1'b1, IDX_PAGE_DIR, 8'ha5, 32'h0, 1'b0, lat);
        chk(32'(paging_pin_oe), 32'ha5);
        chk(32'(paging_pin_out), 32'h3c);
        apb(1'b0, IDX_PAGE_DIR, 8'h0, 32'ha5, 1'b0, lat);
        apb(1'b0, IDX_PAGE_VALUE, 8'h0, 32'h2e, 1'b0, lat);
        chk(lat, 1);
        apb(1'b1, 8'h3f, 8'hff, 32'h0, 1'b1, lat);
        apb(1'b0, 8'h3f, 8'h0, 32'h0, 1'b1, lat);
    endtask
    task automatic t_stretch();
        for (int n = 0; n < 4; n++)
        begin
            stretch_sel <= 2'(n);
            slow <= (n > 1);
            cpu(1'b1, 1'b1, 16'(8 * n), 16'h1234 + 16'(n), 16'h0);
            cpu(1'b0, 1'b1, 16'(8 * n), 16'h0, 16'h1234 + 16'(n));
            cpu(1'b1, 1'b0, 16'(8 * n + 3), 16'h00a5, 16'h0);
            cpu(1'b1, 1'b0, 16'(8 * n + 6), 16'h005a, 16'h0);
        end
        cpu(1'b1, 1'b1, 16'h0041, 16'hbeef, 16'h0);
        cpu(1'b0, 1'b1, 16'h0041, 16'h0, 16'hbeef);
    endtask
    task automatic t_echo();
        stretch_sel <= 2'h1;
        slow <= 1'b0;
        apb(1'b1, IDX_MODE, 8'he1, 32'h0, 1'b0, lat);
        apb(1'b0, IDX_MODE, 8'h0, 32'he1, 1'b0, lat);
        apb(1'b1, IDX_PAGE_DIR, 8'h5a, 32'h0, 1'b0, lat);
        chk(lat, 5);
        chk(32'(paging_pin_oe), 32'h0);
        apb(1'b0, IDX_PAGE_DIR, 8'h0, 32'h5a, 1'b0, lat);
    endtask
    task automatic t_pins();
        for (int i = 0; i < 4; i++)
        begin
            {irq_unmask, nmi_unmask} <= 2'(i);
            repeat (2) @(posedge clk);
            chk(32'(pe_int_route), 32'(i));
        end
        debug_enable_cmd <= 1'b1;
        @(posedge clk);
        debug_enable_cmd <= 1'b0;
        @(posedge clk);
        chk(32'(background_debug_active), 32'h1);
        // stretch enable was cleared earlier: e must run free
        lat = int'(bus_e_clock);
        @(posedge clk);
        chk(32'(bus_e_clock), 32'(lat == 0));
        pipe_out_req <= 1'b1;
        pipe_status_in <= 2'h2;
        repeat (2) @(posedge clk);
        chk(32'({pipe_oe, pipe_status_high, pipe_status_low}), 32'h6);
    endtask
    initial
    begin
        {arst_n, psel, penable, pwrite, cpu_req, cpu_wr, cpu_word, slow} = 8'h0;
        {paddr, pwdata, cpu_addr, cpu_wdata, stretch_sel} = 76'h0;
        {mode_select_c, mode_select_b, mode_select_a} = 3'b111;
        {pipe_status_in, pipe_out_req, paging_pin_in} = 11'h0;
        {irq_unmask, nmi_unmask, debug_enable_cmd} = 3'h0;
        {fail_count, check_count, cycles} = {32'h0, 32'h0, 32'h0};
        t_modes();
        t_protect();
        t_port();
        t_stretch();
        t_echo();
        t_pins();
        test_done();
    end
endmodule // tb_top
